//--- rtl/tmc_pkg.sv
// Shared constants and types for the dual timer/counter pair
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the special-function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_ADDR_MODE = 8'h89;        // Timer mode configuration
  localparam logic [7:0] TMC_ADDR_FIRST_LOW = 8'h8a;   // First timer low half
  localparam logic [7:0] TMC_ADDR_SECOND_LOW = 8'h8b;  // Second timer low half
  localparam logic [7:0] TMC_ADDR_FIRST_HIGH = 8'h8c;  // First timer high half
  localparam logic [7:0] TMC_ADDR_SECOND_HIGH = 8'h8d; // Second timer high half

  // ----------------------------------------------------------------
  // Reset values and read answers
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_MODE_RESET = 8'h00;   // Mode register after reset
  localparam logic [7:0] TMC_COUNT_RESET = 8'h00;  // Count halves after reset
  localparam logic [7:0] TMC_UNMAPPED_READ = 8'h00; // Answer to other addresses

  // ----------------------------------------------------------------
  // Field positions inside the mode register
  // ----------------------------------------------------------------
  localparam int TMC_POS_SECOND = 4;  // Second timer nibble starts here
  localparam int TMC_POS_FIRST = 0;   // First timer nibble starts here
  localparam int TMC_NIBBLE = 4;      // Width of one timer's control nibble

  // ----------------------------------------------------------------
  // Machine cycle timing
  // ----------------------------------------------------------------
  localparam logic [3:0] TMC_MC_CLOCKS = 4'hc;      // Core clocks per machine cycle
  localparam logic [3:0] TMC_PHASE_LAST = TMC_MC_CLOCKS - 4'h1; // Last phase index
  localparam logic [3:0] TMC_SAMPLE_PHASE = 4'h9;   // Input sample phase slot
  localparam logic [3:0] TMC_UPDATE_PHASE = 4'h4;   // Count update phase slot
  localparam logic [4:0] TMC_PRESCALE_MAX = 5'h1f;  // Top of the 5-bit prescaler
  localparam logic [7:0] TMC_HALF_MAX = 8'hff;      // Top of an 8-bit half

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMC_MODE_PRESCALE = 2'b00,  // 8-bit high half over 5-bit prescaler
    TMC_MODE_CASCADE = 2'b01,   // Full 16-bit count
    TMC_MODE_RELOAD = 2'b10,    // 8-bit low half with reload
    TMC_MODE_SPLIT = 2'b11      // Split halves, or stopped
  } tmc_mode_sel_type;

  typedef struct packed {
    logic gate;                 // Count only while gate pin high
    logic counter_sel;          // Count pin edges instead of cycles
    tmc_mode_sel_type mode;     // Mode field high and low bits
  } tmc_ctrl_type;

  typedef struct packed {
    logic [7:0] high;           // High count half
    logic [7:0] low;            // Low count half
  } tmc_count_type;

  typedef struct packed {
    logic ovf;                  // Step overflowed
    tmc_count_type count;       // Count after the step
  } tmc_step_type;

endpackage : tmc_pkg

//--- rtl/tmc_edge_detect.sv
// Count pin sampler and falling edge detector for one timer
`timescale 1ns/10ps

module tmc_edge_detect (
  input wire logic clk_i,     // Core clock
  input wire logic srst_i,    // Synchronous reset, active high
  input wire logic sample_i,  // Sample phase strobe
  input wire logic update_i,  // Update phase strobe
  input wire logic pin_i,     // External count pin level
  output logic edge_o         // Falling edge waiting to be counted
);

  // ----------------------------------------------------------------
  // Sample history
  // ----------------------------------------------------------------
  logic last_sample;  // Pin level at the previous sample phase
  logic fall_seen;    // High last sample, low this sample

  assign fall_seen = sample_i & last_sample & ~pin_i;

  // Reset to low so a pin already low never yields a false edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      last_sample <= 1'b0;
    end else if (sample_i) begin
      last_sample <= pin_i;
    end
  end

  // ----------------------------------------------------------------
  // Pending edge, held until the next update phase
  // ----------------------------------------------------------------
  // Sample and update phases differ, so set and clear never meet
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      edge_o <= 1'b0;
    end else if (fall_seen) begin
      edge_o <= 1'b1;
    end else if (update_i) begin
      edge_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_edge_detect: assert property (@(posedge clk_i) disable iff (srst_i)
    fall_seen |=> (edge_o && !update_i)[*6] ##1 (edge_o && update_i) ##1 !edge_o)
    else $error("falling edge at sample phase not held");

  a_edge_cause: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(edge_o) |-> $past(sample_i) && $past(last_sample) && !$past(pin_i))
    else $error("edge flagged without a high-then-low sample pair");

endmodule : tmc_edge_detect

//--- rtl/tmc_timer_pair.sv
// Dual 16-bit timer/counter pair with its mode register
`timescale 1ns/10ps

// Contract
// - Each timer: separate 8-bit high, low halves
// - Timer function counts once per 12-clock cycle
// - Counter samples pin, counts high-then-low pairs
// - Edge count appears at next cycle's update
// - Second gate bit requires gate pin high
// - Second select bit picks pin or cycles
// - Second mode 00: 8-bit over 5-bit prescaler
// - Second mode 01: 16-bit cascade, no prescaler
// - Second mode 10 reloads; 11 stops it
// - First gate bit requires gate pin high
// - First select bit picks pin or cycles
// - First modes 00, 01, 10 as second
// - First mode 11 splits halves between controls
// - Mode register clears to zero at reset
module tmc_timer_pair (
  input wire logic clk_i,                 // Core clock, 200 MHz
  input wire logic srst_i,                // Synchronous reset, active high
  input wire logic [7:0] sfr_addr_i,      // Register address
  input wire logic sfr_wr_i,              // Register write strobe
  input wire logic sfr_rd_i,              // Register read strobe
  input wire logic [7:0] sfr_wdata_i,     // Register write data
  output logic [7:0] sfr_rdata_o,         // Register read data, next cycle
  input wire logic run_control_first_i,   // First timer run bit
  input wire logic run_control_second_i,  // Second timer run bit
  input wire logic gate_input_first_i,    // First timer gate pin
  input wire logic gate_input_second_i,   // Second timer gate pin
  input wire logic count_input_first_i,   // First timer count pin
  input wire logic count_input_second_i,  // Second timer count pin
  output logic first_ovf_o,               // First timer overflow pulse
  output logic second_ovf_o               // Second timer overflow pulse
);

  // ----------------------------------------------------------------
  // Step function shared by both timers
  // ----------------------------------------------------------------
  // Split mode only steps the low half here; the high half of the
  // first timer is stepped on its own tick further down
  function automatic tmc_pkg::tmc_step_type step_count(
    input tmc_pkg::tmc_mode_sel_type mode,
    input tmc_pkg::tmc_count_type cur
  );
    tmc_pkg::tmc_step_type res;
    res.ovf = 1'b0;
    res.count = cur;
    unique case (mode)
      tmc_pkg::TMC_MODE_PRESCALE: begin
        // Upper three low bits are left as written
        if (cur.low[4:0] == tmc_pkg::TMC_PRESCALE_MAX) begin
          res.count.low[4:0] = 5'h00;
          res.count.high = cur.high + 8'h01;
          res.ovf = (cur.high == tmc_pkg::TMC_HALF_MAX);
        end else begin
          res.count.low[4:0] = cur.low[4:0] + 5'h01;
        end
      end
      tmc_pkg::TMC_MODE_CASCADE: begin
        res.count = cur + 16'h0001;
        res.ovf = (cur == 16'hffff);
      end
      tmc_pkg::TMC_MODE_RELOAD: begin
        if (cur.low == tmc_pkg::TMC_HALF_MAX) begin
          res.count.low = cur.high;
          res.ovf = 1'b1;
        end else begin
          res.count.low = cur.low + 8'h01;
        end
      end
      tmc_pkg::TMC_MODE_SPLIT: begin
        res.count.low = cur.low + 8'h01;
        res.ovf = (cur.low == tmc_pkg::TMC_HALF_MAX);
      end
    endcase
    return res;
  endfunction : step_count

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] timer_mode_config;      // Mode register, both nibbles
  tmc_pkg::tmc_count_type first_count;  // First timer halves
  tmc_pkg::tmc_count_type second_count; // Second timer halves
  logic [3:0] phase;                  // Clock slot within machine cycle

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  tmc_pkg::tmc_ctrl_type ctrl_first;  // First timer control nibble
  tmc_pkg::tmc_ctrl_type ctrl_second; // Second timer control nibble
  logic upd_strobe;                   // Count update slot
  logic smp_strobe;                   // Count pin sample slot
  logic wr_mode;                      // Write to mode register
  logic wr_first_low;                 // Write to first low half
  logic wr_first_high;                // Write to first high half
  logic wr_second_low;                // Write to second low half
  logic wr_second_high;               // Write to second high half
  logic any_count_wr;                 // Any count half written

  assign ctrl_first = timer_mode_config[tmc_pkg::TMC_POS_FIRST +: tmc_pkg::TMC_NIBBLE];
  assign ctrl_second = timer_mode_config[tmc_pkg::TMC_POS_SECOND +: tmc_pkg::TMC_NIBBLE];
  assign upd_strobe = (phase == tmc_pkg::TMC_UPDATE_PHASE);
  assign smp_strobe = (phase == tmc_pkg::TMC_SAMPLE_PHASE);
  assign wr_mode = sfr_wr_i && (sfr_addr_i == tmc_pkg::TMC_ADDR_MODE);
  assign wr_first_low = sfr_wr_i && (sfr_addr_i == tmc_pkg::TMC_ADDR_FIRST_LOW);
  assign wr_first_high = sfr_wr_i && (sfr_addr_i == tmc_pkg::TMC_ADDR_FIRST_HIGH);
  assign wr_second_low = sfr_wr_i && (sfr_addr_i == tmc_pkg::TMC_ADDR_SECOND_LOW);
  assign wr_second_high = sfr_wr_i && (sfr_addr_i == tmc_pkg::TMC_ADDR_SECOND_HIGH);
  assign any_count_wr = wr_first_low | wr_first_high | wr_second_low | wr_second_high;

  // ----------------------------------------------------------------
  // Machine cycle phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase <= 4'h0;
    end else if (phase == tmc_pkg::TMC_PHASE_LAST) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Count pin edge detectors
  // ----------------------------------------------------------------
  // Pins are slow event inputs; the far end holds each level for a
  // full machine cycle, so one sample per cycle is enough
  logic edge_first;   // Falling edge pending on first count pin
  logic edge_second;  // Falling edge pending on second count pin

  tmc_edge_detect u_edge_first (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .sample_i(smp_strobe),
    .update_i(upd_strobe),
    .pin_i(count_input_first_i),
    .edge_o(edge_first)
  );

  tmc_edge_detect u_edge_second (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .sample_i(smp_strobe),
    .update_i(upd_strobe),
    .pin_i(count_input_second_i),
    .edge_o(edge_second)
  );

  // ----------------------------------------------------------------
  // Run enables and ticks
  // ----------------------------------------------------------------
  logic run_first;        // First timer allowed to count
  logic run_second;       // Second timer allowed to count
  logic src_first;        // First timer count source event
  logic src_second;       // Second timer count source event
  logic split_first;      // First timer in split mode
  logic tick_first;       // Step first timer this clock
  logic tick_second;      // Step second timer this clock
  logic tick_first_high;  // Step first high half in split mode

  assign run_first = run_control_first_i & (~ctrl_first.gate | gate_input_first_i);
  assign run_second = run_control_second_i & (~ctrl_second.gate | gate_input_second_i);
  assign src_first = ctrl_first.counter_sel ? edge_first : 1'b1;
  assign src_second = ctrl_second.counter_sel ? edge_second : 1'b1;
  assign split_first = (ctrl_first.mode == tmc_pkg::TMC_MODE_SPLIT);
  assign tick_first = upd_strobe & run_first & src_first;
  // Second timer mode 11 holds it still
  assign tick_second = upd_strobe & run_second & src_second &
                       (ctrl_second.mode != tmc_pkg::TMC_MODE_SPLIT);
  // Borrowed high half counts cycles only, under the second run bit
  assign tick_first_high = upd_strobe & run_control_second_i & split_first;

  // ----------------------------------------------------------------
  // Next count values; a software write beats a same-cycle tick
  // ----------------------------------------------------------------
  tmc_pkg::tmc_step_type step_first;   // First timer stepped
  tmc_pkg::tmc_step_type step_second;  // Second timer stepped
  logic [7:0] first_high_split;        // First high half in split mode
  logic [7:0] next_first_low;          // First low half next
  logic [7:0] next_first_high;         // First high half next
  logic [7:0] next_second_low;         // Second low half next
  logic [7:0] next_second_high;        // Second high half next
  logic next_first_ovf;                // First overflow next
  logic next_second_ovf;               // Second overflow next

  assign step_first = step_count(ctrl_first.mode, first_count);
  assign step_second = step_count(ctrl_second.mode, second_count);
  assign first_high_split = tick_first_high ? first_count.high + 8'h01 : first_count.high;

  assign next_first_low = wr_first_low ? sfr_wdata_i :
                          tick_first ? step_first.count.low : first_count.low;
  assign next_first_high = wr_first_high ? sfr_wdata_i :
                           split_first ? first_high_split :
                           tick_first ? step_first.count.high : first_count.high;
  assign next_second_low = wr_second_low ? sfr_wdata_i :
                           tick_second ? step_second.count.low : second_count.low;
  assign next_second_high = wr_second_high ? sfr_wdata_i :
                            tick_second ? step_second.count.high : second_count.high;
  assign next_first_ovf = tick_first & step_first.ovf;
  // In split mode the borrowed high half takes the second overflow
  assign next_second_ovf = split_first ?
                           (tick_first_high & (first_count.high == tmc_pkg::TMC_HALF_MAX)) :
                           (tick_second & step_second.ovf);

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_mode_config <= tmc_pkg::TMC_MODE_RESET;
    end else if (wr_mode) begin
      timer_mode_config <= sfr_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Count halves and overflow pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      first_count <= {tmc_pkg::TMC_COUNT_RESET, tmc_pkg::TMC_COUNT_RESET};
      second_count <= {tmc_pkg::TMC_COUNT_RESET, tmc_pkg::TMC_COUNT_RESET};
      first_ovf_o <= 1'b0;
      second_ovf_o <= 1'b0;
    end else begin
      first_count <= {next_first_high, next_first_low};
      second_count <= {next_second_high, next_second_low};
      first_ovf_o <= next_first_ovf;
      second_ovf_o <= next_second_ovf;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;  // Selected register for a read

  assign rd_mux = (sfr_addr_i == tmc_pkg::TMC_ADDR_MODE) ? timer_mode_config :
                  (sfr_addr_i == tmc_pkg::TMC_ADDR_FIRST_LOW) ? first_count.low :
                  (sfr_addr_i == tmc_pkg::TMC_ADDR_FIRST_HIGH) ? first_count.high :
                  (sfr_addr_i == tmc_pkg::TMC_ADDR_SECOND_LOW) ? second_count.low :
                  (sfr_addr_i == tmc_pkg::TMC_ADDR_SECOND_HIGH) ? second_count.high :
                  tmc_pkg::TMC_UNMAPPED_READ;

  // Data held until the next read strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mode_reset: assert property (@(posedge clk_i)
    srst_i |=> (timer_mode_config == 8'h00) && (first_count == 16'h0000))
    else $error("mode register not cleared by reset");

  a_phase_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_first |=> (!tick_first)[*8] ##1 (!tick_first)[*3])
    else $error("first timer stepped twice within one machine cycle");

  a_timer_tick: assert property (@(posedge clk_i) disable iff (srst_i)
    (phase == 4'h4 && run_first && !ctrl_first.counter_sel) |-> tick_first)
    else $error("timer function missed a machine cycle");

  a_update_phase: assert property (@(posedge clk_i) disable iff (srst_i)
    (!$past(srst_i) && !$past(any_count_wr) && $changed(first_count.low)) |->
    ($past(phase) == 4'h4))
    else $error("count changed outside the update phase");

  a_gate_first: assert property (@(posedge clk_i) disable iff (srst_i)
    (ctrl_first.gate && !gate_input_first_i) |-> !tick_first)
    else $error("first timer ran with gate pin low");

  a_gate_second: assert property (@(posedge clk_i) disable iff (srst_i)
    (ctrl_second.gate && !gate_input_second_i) |-> !tick_second)
    else $error("second timer ran with gate pin low");

  a_counter_edge: assert property (@(posedge clk_i) disable iff (srst_i)
    (tick_first && ctrl_first.counter_sel) |-> edge_first)
    else $error("counter function stepped without a pin edge");

  a_cascade_carry: assert property (@(posedge clk_i) disable iff (srst_i)
    (tick_second && ctrl_second.mode == tmc_pkg::TMC_MODE_CASCADE &&
     second_count.low == 8'hff && !any_count_wr)
    |=> second_count.low == 8'h00 && second_count.high == $past(second_count.high) + 8'h01)
    else $error("16-bit mode failed to carry into the high half");

  a_reload_low: assert property (@(posedge clk_i) disable iff (srst_i)
    (tick_first && ctrl_first.mode == tmc_pkg::TMC_MODE_RELOAD &&
     first_count.low == 8'hff && !any_count_wr)
    |=> first_count.low == $past(first_count.high) && first_ovf_o)
    else $error("reload mode did not reload the low half");

  a_prescale_carry: assert property (@(posedge clk_i) disable iff (srst_i)
    (tick_first && ctrl_first.mode == tmc_pkg::TMC_MODE_PRESCALE &&
     first_count.low[4:0] == 5'h1f && !any_count_wr)
    |=> first_count.high == $past(first_count.high) + 8'h01 && first_count.low[4:0] == 5'h00)
    else $error("prescaler overflow did not step the high half");

  a_second_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    (ctrl_second.mode == tmc_pkg::TMC_MODE_SPLIT && !wr_second_low && !wr_second_high)
    |=> $stable(second_count))
    else $error("second timer moved while stopped");

  a_split_high: assert property (@(posedge clk_i) disable iff (srst_i)
    (split_first && !run_control_second_i && !wr_first_high) |=> $stable(first_count.high))
    else $error("split high half moved without second run bit");

endmodule : tmc_timer_pair

//--- bench/tmc_pin_model.sv
// Far-side model of the count and gate pins of both timers
`timescale 1ns/10ps

module tmc_pin_model (
  input wire logic clk_i,          // Core clock
  input wire logic go_i,           // Start a pulse train
  input wire logic [3:0] pulses_i, // Falling edges to make
  input wire logic [1:0] gate_i,   // Wanted gate pin levels
  output logic [1:0] count_o,      // Count pins, both timers
  output logic [1:0] gate_o,       // Gate pins, both timers
  output logic busy_o              // Pulse train running
);
  assign gate_o = gate_i; // Gate pins follow the bench's wish

  // Pulse train; a shorter level could slip between two samples
  initial begin
    count_o = 2'b00;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        repeat (pulses_i) begin
          count_o <= 2'b11; // High held a full machine cycle
          repeat (12) @(posedge clk_i);
          count_o <= 2'b00; // Low held a full machine cycle
          repeat (12) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : tmc_pin_model

//--- bench/tmc_timer_pair_tb.sv
// Self-checking bench for the dual timer/counter pair
`timescale 1ns/10ps

module tmc_timer_pair_tb;
  logic clk_i, srst_i, sfr_wr_i, sfr_rd_i, go, busy, rd_seen;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, r, e;
  logic [1:0] run, gate_req, cnt_pin, gate_pin, ovf, eo;
  logic [1:0] ovf_q[$]; // Expected overflow pulses {second, first}, oldest first
  logic [7:0] exp_q[$]; // Expected read answers, oldest first
  logic [7:0] hi0[3] = '{8'h05, 8'h12, 8'hf0}; // High preload per mode
  logic [7:0] elo[3] = '{8'he1, 8'h01, 8'hf1}; // Low after 3 steps
  logic [7:0] ehi[3] = '{8'h06, 8'h13, 8'hf0}; // High after 3 steps
  logic [31:0] seed;
  int n_errors, n_tests, cyc, w;

  tmc_timer_pair tmc_timer_pair_inst (.clk_i, .srst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .run_control_first_i(run[0]), .run_control_second_i(run[1]),
    .gate_input_first_i(gate_pin[0]), .gate_input_second_i(gate_pin[1]),
    .count_input_first_i(cnt_pin[0]), .count_input_second_i(cnt_pin[1]),
    .first_ovf_o(ovf[0]), .second_ovf_o(ovf[1]));
  tmc_pin_model tmc_pin_model_inst (.clk_i, .go_i(go), .pulses_i(4'h3), .gate_i(gate_req),
    .count_o(cnt_pin), .gate_o(gate_pin), .busy_o(busy));

  // ----------------------------------------------------------------
  // Clock, bus tasks and closing report
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
  endtask : rd

  // Same preload into both timers
  task automatic ld(input logic [7:0] lo, input logic [7:0] hi);
    wr(8'h8a, lo);
    wr(8'h8c, hi);
    wr(8'h8b, lo);
    wr(8'h8d, hi);
  endtask : ld

  // Run bits high for exactly k machine cycles: exactly k steps
  task automatic go_run(input logic [1:0] rb, input int k);
    @(posedge clk_i);
    run <= rb;
    repeat (12 * k) @(posedge clk_i);
    run <= 2'b00;
  endtask : go_run

  task automatic stop_test();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // Read data lands one cycle after the strobe; compare mid-cycle
  always @(posedge clk_i) rd_seen <= sfr_rd_i;
  always @(negedge clk_i) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      n_tests++;
      if (sfr_rdata_o !== e) begin
        $display("unexpected at %0t: read %h, wanted %h", $time, sfr_rdata_o, e);
        n_errors++;
      end
    end
  end

  // Every overflow pulse must match the oldest expected one
  always @(negedge clk_i) begin
    if (ovf !== 2'b00) begin
      eo = (ovf_q.size() > 0) ? ovf_q.pop_front() : 2'b00;
      n_tests++;
      if (ovf !== eo) begin
        $display("unexpected at %0t: overflow %b, wanted %b", $time, ovf, eo);
        n_errors++;
      end
    end
  end

  // Hang guard, about ten times the roughly 600 cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      $display("unexpected at %0t: run timed out", $time);
      n_errors++;
      stop_test();
    end
  end

  initial begin
    srst_i = 1'b1;
    {sfr_wr_i, sfr_rd_i, go, run, gate_req} = 7'h00;
    {sfr_addr_i, sfr_wdata_i} = 16'h0000;
    seed = 32'h1c7f;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(tmc_pkg::TMC_ADDR_MODE, tmc_pkg::TMC_MODE_RESET);
    for (int a = 8'h8a; a < 8'h8e; a++) rd(8'(a), tmc_pkg::TMC_COUNT_RESET);
    rd(8'h8e, tmc_pkg::TMC_UNMAPPED_READ);
    r = 8'($random(seed));
    wr(tmc_pkg::TMC_ADDR_MODE, r);
    rd(tmc_pkg::TMC_ADDR_MODE, r);
    // Modes 00, 01 and 10 on each timer; the idle timer's low half must not move
    for (int i = 0; i < 3; i++) begin
      for (int t = 0; t < 2; t++) begin
        ld(8'hfe, hi0[i]);
        wr(8'h89, t ? {2'b00, 2'(i), 4'h0} : {4'h3, 2'b00, 2'(i)});
        if (i == 2) ovf_q.push_back(t ? 2'b10 : 2'b01); // Reload wraps once
        go_run(t ? 2'b10 : 2'b11, 3);
        rd(t ? 8'h8b : 8'h8a, elo[i]);
        rd(t ? 8'h8d : 8'h8c, ehi[i]);
        rd(t ? 8'h8a : 8'h8b, 8'hfe);
      end
    end
    ld(8'h00, 8'h00);
    wr(8'h89, 8'h99);
    go_run(2'b11, 2);
    gate_req <= 2'b11;
    go_run(2'b11, 2);
    rd(8'h8a, 8'h02);
    rd(8'h8b, 8'h02);
    ld(8'h00, 8'h00);
    wr(8'h89, 8'h03);
    go_run(2'b11, 3);
    go_run(2'b10, 2);
    rd(8'h8a, 8'h03);
    rd(8'h8c, 8'h05);
    ld(8'h00, 8'h00);
    wr(8'h89, 8'h55);
    @(posedge clk_i);
    run <= 2'b11;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    w = 0;
    while (busy && w < 300) begin
      @(posedge clk_i);
      w++;
    end
    if (w == 300) begin
      $display("unexpected at %0t: pin model never finished", $time);
      n_errors++;
    end
    repeat (24) @(posedge clk_i);
    run <= 2'b00;
    rd(8'h8a, 8'h03);
    rd(8'h8b, 8'h03);
    // Let the last read land before the verdict
    repeat (2) @(posedge clk_i);
    if (exp_q.size() + ovf_q.size() != 0) begin
      $display("unexpected at %0t: %0d results never seen", $time, exp_q.size() + ovf_q.size());
      n_errors++;
    end
    stop_test();
  end
endmodule : tmc_timer_pair_tb
